/* File: logic/cco_core.sv */
`timescale 1ns/1ps
module cco_core (
   input wire logic I_SYS_CLK,
   input wire logic I_RST_B,
   input wire logic I_CYC,
   input wire logic I_STB,
   input wire logic I_WE,
   input wire logic [3:0] I_ADR,
   input wire logic [3:0] I_SEL,
   input wire logic [31:0] I_DAT,
   output logic [31:0] O_DAT,
   output logic O_ACK,
   output logic O_WDT_CLR,
   output logic O_PRESC_CLR
);
   localparam int W = cco_pkg::DATA_W;
   logic [W-1:0] file_mem [cco_pkg::FILE_N];
   logic [W-1:0] wreg;
   logic [W-1:0] status;
   logic [11:0] insn;
   logic psa_wdt;
   logic exec;
   cco_pkg::cco_op_t op;
   logic to_file;
   logic [cco_pkg::FILE_AW-1:0] addr;
   logic [W-1:0] result;
   logic req;

   // All checks below run on the one core clock
   default clocking cb_sys @(posedge I_SYS_CLK); endclocking
   default disable iff (!I_RST_B);

   // Writing the instruction register executes it in that same cycle
   assign req = I_CYC && I_STB && !O_ACK;
   assign exec = req && I_WE && I_ADR == cco_pkg::ADR_INSN && I_SEL[1:0] == 2'h3;

   cco_decode u_dec (
      .i_insn(I_DAT[11:0]),
      .o_op(op),
      .o_to_file(to_file),
      .o_addr(addr)
   );

   always_comb begin
      result = '0;
      if (op == cco_pkg::CCO_COMPLEMENT_FILE_OP) begin
         result = ~file_mem[addr]; // [RQ6]
      end
   end

   always_ff @(posedge I_SYS_CLK) begin
      if (!I_RST_B) begin
         insn <= 12'h000;
      end else if (exec) begin
         insn <= I_DAT[11:0];
      end
   end

   always_ff @(posedge I_SYS_CLK) begin
      if (!I_RST_B) begin
         for (int i = 0; i < cco_pkg::FILE_N; i++) begin
            file_mem[i] <= cco_pkg::FILE_RST;
         end
      end else if (exec && op == cco_pkg::CCO_CLEAR_FILE_OP) begin
         file_mem[addr] <= '0; // [RQ1]
      end else if (exec && op == cco_pkg::CCO_COMPLEMENT_FILE_OP && to_file) begin
         file_mem[addr] <= result; // [RQ5] [RQ6]
      end
   end

   always_ff @(posedge I_SYS_CLK) begin
      if (!I_RST_B) begin
         wreg <= cco_pkg::WREG_RST;
      end else if (exec && op == cco_pkg::CCO_CLEAR_WORKING_OP) begin
         wreg <= '0; // [RQ2]
      end else if (exec && op == cco_pkg::CCO_COMPLEMENT_FILE_OP && !to_file) begin
         wreg <= result; // [RQ5] [RQ6]
      end else if (req && I_WE && I_ADR == cco_pkg::ADR_WREG && I_SEL[0]) begin
         wreg <= I_DAT[W-1:0];
      end
   end

   always_ff @(posedge I_SYS_CLK) begin
      if (!I_RST_B) begin
         status <= cco_pkg::STATUS_RST;
      end else if (exec) begin
         unique case (op)
            cco_pkg::CCO_CLEAR_FILE_OP, cco_pkg::CCO_CLEAR_WORKING_OP:
               status[cco_pkg::STAT_Z] <= 1'b1; // [RQ1] [RQ3]
            cco_pkg::CCO_COMPLEMENT_FILE_OP:
               status[cco_pkg::STAT_Z] <= (result == '0); // [RQ6]
            cco_pkg::CCO_CLEAR_WATCHDOG_OP: begin
               status[cco_pkg::STAT_TO] <= 1'b1; // [RQ4]
               status[cco_pkg::STAT_PD] <= 1'b1; // [RQ4]
            end
            cco_pkg::CCO_NONE: ;
         endcase
      end else if (req && I_WE && I_ADR == cco_pkg::ADR_STATUS && I_SEL[0]) begin
         status <= I_DAT[W-1:0];
      end
   end

   always_ff @(posedge I_SYS_CLK) begin
      if (!I_RST_B) begin
         psa_wdt <= 1'b0;
      end else if (req && I_WE && I_ADR == cco_pkg::ADR_CTRL && I_SEL[0]) begin
         psa_wdt <= I_DAT[cco_pkg::CTRL_PSA];
      end
   end

   // One-cycle pulses to the watchdog; prescaler only when it belongs to it
   always_ff @(posedge I_SYS_CLK) begin
      if (!I_RST_B) begin
         O_WDT_CLR <= 1'b0;
         O_PRESC_CLR <= 1'b0;
      end else begin
         O_WDT_CLR <= exec && op == cco_pkg::CCO_CLEAR_WATCHDOG_OP; // [RQ4]
         O_PRESC_CLR <= exec && op == cco_pkg::CCO_CLEAR_WATCHDOG_OP && psa_wdt; // [RQ4]
      end
   end

   always_ff @(posedge I_SYS_CLK) begin
      if (!I_RST_B) begin
         O_ACK <= 1'b0;
         O_DAT <= 32'h00000000;
      end else begin
         O_ACK <= req;
         O_DAT <= 32'h00000000;
         if (req && !I_WE) begin
            unique case (I_ADR)
               cco_pkg::ADR_WREG: O_DAT <= {24'h000000, wreg};
               cco_pkg::ADR_STATUS: O_DAT <= {24'h000000, status};
               cco_pkg::ADR_INSN: O_DAT <= {20'h00000, insn};
               cco_pkg::ADR_CTRL: O_DAT <= {31'h00000000, psa_wdt};
               default: O_DAT <= 32'h00000000;
            endcase
         end
      end
   end

   property p_clear_working_op_zero;
      @(posedge I_SYS_CLK) disable iff (!I_RST_B)
      exec && op == cco_pkg::CCO_CLEAR_WORKING_OP |=> wreg == '0
         && status[cco_pkg::STAT_Z] && status[7:3] == $past(status[7:3])
         && status[1:0] == $past(status[1:0]);
   endproperty
   a_clear_working_op_zero: assert property (p_clear_working_op_zero) // [RQ2] [RQ3]
      else $error("clear working failed");
   property p_clear_file_op;
      @(posedge I_SYS_CLK) disable iff (!I_RST_B)
      exec && op == cco_pkg::CCO_CLEAR_FILE_OP |=> file_mem[$past(addr)] == '0
         && status[cco_pkg::STAT_Z];
   endproperty
   a_clear_file_op: assert property (p_clear_file_op) else $error("clear file failed"); // [RQ1]
   property p_wdt;
      @(posedge I_SYS_CLK) disable iff (!I_RST_B)
      exec && op == cco_pkg::CCO_CLEAR_WATCHDOG_OP |=> O_WDT_CLR
         && O_PRESC_CLR == $past(psa_wdt) && status[4:3] == 2'h3 ##1 !O_WDT_CLR;
   endproperty
   a_wdt: assert property (p_wdt) else $error("watchdog clear failed"); // [RQ4]
   property p_complement_file_op_w;
      @(posedge I_SYS_CLK) disable iff (!I_RST_B)
      exec && op == cco_pkg::CCO_COMPLEMENT_FILE_OP && !to_file |=>
         wreg == ~$past(file_mem[addr]) && file_mem[$past(addr)] == $past(file_mem[addr]);
   endproperty
   a_complement_file_op_w: assert property (p_complement_file_op_w) else $error("complement to w failed"); // [RQ5]
   property p_complement_file_op_z;
      @(posedge I_SYS_CLK) disable iff (!I_RST_B)
      exec && op == cco_pkg::CCO_COMPLEMENT_FILE_OP |=>
         status[cco_pkg::STAT_Z] == ($past(file_mem[addr]) == 8'hFF);
   endproperty
   a_complement_file_op_z: assert property (p_complement_file_op_z) else $error("complement zero failed"); // [RQ6]
   property p_complement_file_op_f;
      @(posedge I_SYS_CLK) disable iff (!I_RST_B)
      exec && op == cco_pkg::CCO_COMPLEMENT_FILE_OP && to_file |=>
         file_mem[$past(addr)] == ~$past(file_mem[addr]);
   endproperty
   a_complement_file_op_f: assert property (p_complement_file_op_f) else $error("complement to f failed"); // [RQ5]
   c_clear_working_op: cover property (@(posedge I_SYS_CLK) exec && op == cco_pkg::CCO_CLEAR_WORKING_OP);
   c_wdt: cover property (@(posedge I_SYS_CLK) O_PRESC_CLR);
   c_complement_file_op: cover property (@(posedge I_SYS_CLK) exec && op == cco_pkg::CCO_COMPLEMENT_FILE_OP);

   // Decoded execute strobes, shared by the checks below
   function automatic logic fires(
      input logic strobe,
      input cco_pkg::cco_op_t kind,
      input cco_pkg::cco_op_t want
   );
      return strobe && kind == want;
   endfunction

   logic exec_clear_file_op;
   logic exec_clear_working_op;
   logic exec_wdt;
   logic exec_complement_file_op;
   assign exec_clear_file_op = fires(exec, op, cco_pkg::CCO_CLEAR_FILE_OP);
   assign exec_clear_working_op = fires(exec, op, cco_pkg::CCO_CLEAR_WORKING_OP);
   assign exec_wdt = fires(exec, op, cco_pkg::CCO_CLEAR_WATCHDOG_OP);
   assign exec_complement_file_op = fires(exec, op, cco_pkg::CCO_COMPLEMENT_FILE_OP);

   c_clear_file_op: cover property (exec_clear_file_op);
   c_complement_file_op_w: cover property (exec_complement_file_op && !to_file);

   // Ack is a single registered pulse, so a held request is taken again every other cycle
   property p_ack_once;
      O_ACK |=> !O_ACK;
   endproperty
   a_ack_once: assert property (p_ack_once) else $error("ack held");

   property p_ack_answer;
      req |=> O_ACK;
   endproperty
   a_ack_answer: assert property (p_ack_answer) else $error("ack missing");

   property p_ack_idle;
      !req |=> !O_ACK;
   endproperty
   a_ack_idle: assert property (p_ack_idle) else $error("stray ack");

   property p_dat_quiet;
      !O_ACK |-> O_DAT == 32'h00000000;
   endproperty
   a_dat_quiet: assert property (p_dat_quiet) else $error("data not idle");

   property p_rd_wreg;
      req && !I_WE && I_ADR == cco_pkg::ADR_WREG
         |=> O_DAT == {24'h000000, $past(wreg)};
   endproperty
   a_rd_wreg: assert property (p_rd_wreg) else $error("bad w readback");

   property p_rd_status;
      req && !I_WE && I_ADR == cco_pkg::ADR_STATUS
         |=> O_DAT == {24'h000000, $past(status)};
   endproperty
   a_rd_status: assert property (p_rd_status) else $error("bad status read");

   property p_rd_ctrl;
      req && !I_WE && I_ADR == cco_pkg::ADR_CTRL
         |=> O_DAT == {31'h00000000, $past(psa_wdt)};
   endproperty
   a_rd_ctrl: assert property (p_rd_ctrl) else $error("bad control read");

   property p_ctrl_write;
      req && I_WE && I_ADR == cco_pkg::ADR_CTRL && I_SEL[0]
         |=> psa_wdt == $past(I_DAT[cco_pkg::CTRL_PSA]);
   endproperty
   a_ctrl_write: assert property (p_ctrl_write) else $error("control lost");

   property p_insn_keep;
      exec |=> insn == $past(I_DAT[11:0]);
   endproperty
   a_insn_keep: assert property (p_insn_keep) else $error("insn not held");

   property p_code_clear_working_op;
      exec && I_DAT[11:0] == cco_pkg::OPC_CLR_W |-> exec_clear_working_op;
   endproperty
   a_code_clear_working_op: assert property (p_code_clear_working_op) // [RQ2]
      else $error("clear working not decoded");

   property p_code_clear_file_op;
      exec && I_DAT[11:6] == cco_pkg::OPC_CLR_F && I_DAT[5] |-> exec_clear_file_op;
   endproperty
   a_code_clear_file_op: assert property (p_code_clear_file_op) // [RQ1]
      else $error("clear file not decoded");

   property p_code_complement_file_op;
      exec && I_DAT[11:6] == cco_pkg::OPC_COM_F |-> exec_complement_file_op;
   endproperty
   a_code_complement_file_op: assert property (p_code_complement_file_op) // [RQ6]
      else $error("complement not decoded");

   property p_code_wdt;
      exec && I_DAT[11:0] == cco_pkg::OPC_CLR_WDT |-> exec_wdt;
   endproperty
   a_code_wdt: assert property (p_code_wdt) // [RQ4]
      else $error("watchdog clear not decoded");

   property p_wdt_quiet;
      !exec_wdt |=> !O_WDT_CLR;
   endproperty
   a_wdt_quiet: assert property (p_wdt_quiet) // [RQ4]
      else $error("stray watchdog clear");

   property p_presc_gate;
      O_PRESC_CLR |-> O_WDT_CLR;
   endproperty
   a_presc_gate: assert property (p_presc_gate) // [RQ4]
      else $error("prescaler cleared alone");

   property p_wdt_keep;
      exec_wdt |=> wreg == $past(wreg) && status[2:0] == $past(status[2:0])
         && status[7:5] == $past(status[7:5]);
   endproperty
   a_wdt_keep: assert property (p_wdt_keep) // [RQ4]
      else $error("watchdog clear disturbed state");

   property p_clear_file_op_keep;
      exec_clear_file_op |=> wreg == $past(wreg) && status[7:3] == $past(status[7:3])
         && status[1:0] == $past(status[1:0]);
   endproperty
   a_clear_file_op_keep: assert property (p_clear_file_op_keep) // [RQ1]
      else $error("clear file disturbed state");

   property p_complement_file_op_keep;
      exec_complement_file_op && to_file |=> wreg == $past(wreg);
   endproperty
   a_complement_file_op_keep: assert property (p_complement_file_op_keep) // [RQ5]
      else $error("complement to f touched w");

   property p_complement_file_op_flags;
      exec_complement_file_op |=> status[7:3] == $past(status[7:3])
         && status[1:0] == $past(status[1:0]);
   endproperty
   a_complement_file_op_flags: assert property (p_complement_file_op_flags) // [RQ6]
      else $error("complement disturbed status");

   // Without an execute or a bus write W must hold its value
   property p_w_hold;
      !exec && !(req && I_WE && I_ADR == cco_pkg::ADR_WREG && I_SEL[0])
         |=> wreg == $past(wreg);
   endproperty
   a_w_hold: assert property (p_w_hold) else $error("w changed alone");
endmodule // cco_core

/* File: logic/cco_decode.sv */
`timescale 1ns/1ps
module cco_decode (
   input wire logic [11:0] i_insn,
   output cco_pkg::cco_op_t o_op,
   output logic o_to_file,
   output logic [cco_pkg::FILE_AW-1:0] o_addr
);
   always_comb begin
      o_op = cco_pkg::CCO_NONE;
      if (i_insn == cco_pkg::OPC_CLR_W) begin
         o_op = cco_pkg::CCO_CLEAR_WORKING_OP; // [RQ2]
      end else if (i_insn == cco_pkg::OPC_CLR_WDT) begin
         o_op = cco_pkg::CCO_CLEAR_WATCHDOG_OP; // [RQ4]
      end else if (i_insn[11:6] == cco_pkg::OPC_CLR_F && i_insn[5]) begin
         o_op = cco_pkg::CCO_CLEAR_FILE_OP; // [RQ1]
      end else if (i_insn[11:6] == cco_pkg::OPC_COM_F) begin
         o_op = cco_pkg::CCO_COMPLEMENT_FILE_OP; // [RQ6]
      end
   end
   assign o_to_file = i_insn[cco_pkg::DEST_BIT];
   assign o_addr = i_insn[cco_pkg::FILE_AW-1:0];
endmodule // cco_decode

/* File: pkg/cco_pkg.sv */
// Overview of operation
// RQ1 - Clearing a file register writes zero to it and sets the zero flag in one single-word cycle.
// RQ2 - The fixed clear-working-register pattern loads zero into the working register within one cycle.
// RQ3 - Clearing the working register also sets the zero flag and leaves the other status bits alone.
// RQ4 - Clearing the watchdog resets its counter and the assigned prescaler and sets time-out and power-down.
// RQ5 - A destination bit of zero sends the result to the working register, one sends it back to the file.
// RQ6 - Complementing a file register inverts every bit, stores it at the destination and updates zero.
package cco_pkg;
   localparam int DATA_W = 8;
   localparam int FILE_N = 32;
   localparam int FILE_AW = 5;
   localparam logic [11:0] OPC_CLR_W = 12'h040;
   localparam logic [11:0] OPC_CLR_WDT = 12'h004;
   localparam logic [5:0] OPC_CLR_F = 6'h01;
   localparam logic [5:0] OPC_COM_F = 6'h09;
   localparam int DEST_BIT = 5;
   localparam int STAT_Z = 2;
   localparam int STAT_PD = 3;
   localparam int STAT_TO = 4;
   localparam logic [7:0] STATUS_RST = 8'h18;
   localparam logic [7:0] WREG_RST = 8'h00;
   localparam logic [7:0] FILE_RST = 8'h00;
   localparam logic [3:0] ADR_WREG = 4'h0;
   localparam logic [3:0] ADR_STATUS = 4'h4;
   localparam logic [3:0] ADR_INSN = 4'h8;
   localparam logic [3:0] ADR_CTRL = 4'hC;
   localparam int CTRL_PSA = 0;
   typedef enum logic [2:0] {
      CCO_NONE, CCO_CLEAR_FILE_OP, CCO_CLEAR_WORKING_OP, CCO_CLEAR_WATCHDOG_OP, CCO_COMPLEMENT_FILE_OP
   } cco_op_t;
endpackage

/* File: verification/clear_and_complement_ops_tb.sv */
`timescale 1ns/1ps
module clear_and_complement_ops_tb;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic we = 1'b0;
   logic [3:0] adr = 4'h0;
   logic [3:0] sel = 4'hF;
   logic [31:0] wdat = 32'h0;
   logic [31:0] rdat, rd;
   logic ack, wdt, presc, wdt_seen, presc_seen;
   int failures = 0;
   int cmp_count = 0;
   logic [7:0] fm [32];
   logic [7:0] w, st, r;
   logic [4:0] f;
   logic d;
   always #2 clk = ~clk;
   cco_core dut (.I_SYS_CLK(clk), .I_RST_B(rst_b), .I_CYC(cyc), .I_STB(stb),
      .I_WE(we), .I_ADR(adr), .I_SEL(sel), .I_DAT(wdat), .O_DAT(rdat),
      .O_ACK(ack), .O_WDT_CLR(wdt), .O_PRESC_CLR(presc));
   task close_out;
      if (failures == 0 && cmp_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         failures++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // Pulses are collected over the whole wait, sampled at each rising edge
   task wb(input logic wr, input logic [3:0] a, input logic [31:0] dt);
      int n;
      n = 0;
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= wr;
      adr <= a;
      wdat <= dt;
      wdt_seen = 1'b0;
      presc_seen = 1'b0;
      do begin
         @(posedge clk);
         n++;
         wdt_seen = wdt_seen | wdt;
         presc_seen = presc_seen | presc;
      end while (ack !== 1'b1 && n < 20);
      if (n >= 20)
         failures++;
      rd = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask
   function automatic logic [7:0] after_wdt(input logic [7:0] s);
      after_wdt = s;
      after_wdt[cco_pkg::STAT_TO] = 1'b1;
      after_wdt[cco_pkg::STAT_PD] = 1'b1;
   endfunction
   task ex(input logic [11:0] insn);
      wb(1'b1, 4'h8, {20'h0, insn});
   endtask
   initial begin
      #80000;
      failures++;
      close_out();
   end
   initial begin
      void'($urandom(7));
      foreach (fm[i]) fm[i] = cco_pkg::FILE_RST;
      st = cco_pkg::STATUS_RST;
      w = cco_pkg::WREG_RST;
      repeat (10) @(posedge clk);
      rst_b <= 1'b1;
      wb(1'b0, 4'h1, 32'h0);
      check(rd, 32'h0);
      // Random mix of clears, complements and software writes to W
      repeat (60) begin
         f = 5'($urandom_range(31));
         d = 1'($urandom_range(1));
         case ($urandom_range(3))
            0: begin
               ex({cco_pkg::OPC_CLR_F, 1'b1, f});
               fm[f] = 8'h00;
               st[cco_pkg::STAT_Z] = 1'b1;
            end
            1: begin
               ex({cco_pkg::OPC_COM_F, d, f});
               r = ~fm[f];
               if (d) fm[f] = r; else w = r;
               st[cco_pkg::STAT_Z] = (r == 8'h00);
            end
            2: begin
               ex(cco_pkg::OPC_CLR_W);
               w = 8'h00;
               st[cco_pkg::STAT_Z] = 1'b1;
            end
            default: begin
               w = 8'($urandom_range(255));
               wb(1'b1, 4'h0, {24'h0, w});
            end
         endcase
         wb(1'b0, 4'h0, 32'h0);
         check(rd, {24'h0, w});
         wb(1'b0, 4'h4, 32'h0);
         check(rd, {24'h0, st});
      end
      // Watchdog clear with prescaler unassigned, then assigned
      for (int p = 0; p < 2; p++) begin
         wb(1'b1, 4'hC, 32'(p));
         wb(1'b1, 4'h4, 32'h0);
         wb(1'b0, 4'h4, 32'h0);
         st = rd[7:0];
         ex(cco_pkg::OPC_CLR_WDT);
         check(32'(wdt_seen), 32'h1);
         check(32'(presc_seen), 32'(p));
         wb(1'b0, 4'h4, 32'h0);
         check(rd, {24'h0, after_wdt(st)});
      end
      close_out();
   end
endmodule // clear_and_complement_ops_tb
